/* verilog/hsl_pkg.sv */
`default_nettype none
package hsl_pkg;
    localparam logic [7:0] CMD_PM_WR = 8'hC0;
    localparam logic [7:0] CMD_JCON  = 8'hC4;
    localparam logic [7:0] CMD_CM_WR = 8'hA0;
    localparam logic [7:0] CMD_CM_RW = 8'hA4;
    localparam logic [7:0] CMD_OM_WR = 8'h90;
    localparam logic [7:0] CMD_OM_RW = 8'h94;
    localparam logic [7:0] CMD_PREP  = 8'h88;
    localparam logic [7:0] CMD_CTRL  = 8'h06;
    localparam logic [7:0] CMD_PM_RD = 8'hC3;
    localparam logic [7:0] CMD_CM_RD = 8'hA1;
    localparam logic [7:0] CMD_OM_RD = 8'h91;

    localparam int PM_DEPTH  = 448;
    localparam int CM_DEPTH  = 384;
    localparam int OM_DEPTH  = 32;
    localparam int BUF_DEPTH = 16;

    localparam logic [1:0]  SEL_PM = 2'h0;
    localparam logic [1:0]  SEL_CM = 2'h1;
    localparam logic [1:0]  SEL_OM = 2'h2;

    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam int          CTRL_I2S_BIT = 0;
    localparam logic [7:0]  JUMP_RST     = 8'h00;

    localparam logic [3:0]  WRITE_CYC   = 4'h4;
    localparam int          SYS_CLK_NS  = 5;
    localparam int          LINK_HALF_NS = 60;
    localparam logic [4:0]  HALF_CYC    =
        5'(LINK_HALF_NS / SYS_CLK_NS);
    localparam logic [7:0]  GUARD_CYC   = 8'h20;
    localparam logic [5:0]  FRAME_WAIT_SLAVE = 6'h03;

    typedef enum logic [1:0] {
        HOP_BYTE,
        HOP_READ,
        HOP_RESTART,
        HOP_RELEASE
    } hsl_op_t;
endpackage
`default_nettype wire

/* verilog/hsl_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface hsl_link_if;
    logic chip_select_n;
    logic write_request_n;
    logic serial_clock;
    logic serial_in;
    logic serial_out;
    logic host_ready;
    logic frame_clock;
    logic converter_reset_n;
    logic processor_reset_n;

    modport dev (
        input  chip_select_n,
        input  write_request_n,
        input  serial_clock,
        input  serial_in,
        input  frame_clock,
        input  converter_reset_n,
        input  processor_reset_n,
        output serial_out,
        output host_ready
    );

    modport host (
        output chip_select_n,
        output write_request_n,
        output serial_clock,
        output serial_in,
        output converter_reset_n,
        output processor_reset_n,
        input  frame_clock,
        input  serial_out,
        input  host_ready
    );
endinterface
`default_nettype wire

/* verilog/hsl_dev_end.sv */
`timescale 1ns/10ps
`default_nettype none
module hsl_dev_end
    import hsl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    hsl_link_if.dev          link,
    input  wire logic        hard_jump_input,
    input  wire logic [8:0]  jump_condition_field,
    input  wire logic        exec_valid,
    input  wire logic        exec_kind,
    input  wire logic [8:0]  exec_addr,
    input  wire logic [1:0]  user_sel,
    input  wire logic [8:0]  user_addr,
    output logic      [31:0] user_data_q,
    output logic      [15:0] ctrl_reg_q,
    output logic      [7:0]  jump_code_q,
    output logic             jump_taken_q,
    output logic             in_reset_q,
    output logic             ready_q,
    output logic      [31:0] rsh_q
);
    typedef enum logic [3:0] {
        ST_CMD, ST_ADH, ST_ADL, ST_DATA, ST_BUSY,
        ST_JWAIT, ST_RARM, ST_RLOW, ST_RSHIFT, ST_HOLD
    } hsl_dst_t;

    logic [7:0]  s1_q, s2_q, p_q;
    logic        sck, si, active, in_rst, lr, lr_p;
    logic        sck_rise, sck_fall, si_rise, si_fall, wrq_fall, lr_rise;
    logic        collect, byte_done, commit, rw_hit;
    logic [7:0]  rx_byte;
    logic [31:0] wdata;
    hsl_dst_t    st_q;
    logic [2:0]  bit_q;
    logic [6:0]  sh_q;
    logic [7:0]  cmd_q, jpend_q;
    logic [8:0]  addr_q, rw_addr_q;
    logic [23:0] word_q;
    logic [1:0]  dcnt_q;
    logic [3:0]  wait_q;
    logic [4:0]  bcnt_q, rw_idx_q;
    logic        rw_act_q, rw_kind_q;
    logic [31:0] pm_q  [PM_DEPTH];
    logic [15:0] cm_q  [CM_DEPTH];
    logic [15:0] om_q  [OM_DEPTH];
    logic [15:0] buf_q [BUF_DEPTH];

    function automatic logic [1:0] last_idx(input logic [7:0] c);
        if (c == CMD_PM_WR)
            last_idx = 2'h3;
        else if (c == CMD_JCON)
            last_idx = 2'h0;
        else
            last_idx = 2'h1;
    endfunction

    function automatic logic cmd_ok(input logic [7:0] c, input logic r);
        if (c == CMD_JCON)
            cmd_ok = 1'b1;
        else if (r)
            cmd_ok = c inside {CMD_PM_WR, CMD_CM_WR, CMD_OM_WR, CMD_CTRL,
                               CMD_PM_RD, CMD_CM_RD, CMD_OM_RD};
        else
            cmd_ok = c inside {CMD_CM_RW, CMD_OM_RW, CMD_PREP};
    endfunction

    // right-justified memory word
    function automatic logic [31:0] peek(input logic [1:0] s,
                                         input logic [8:0] a);
        peek = 32'h0000_0000;
        if (s == SEL_PM && a < PM_DEPTH)
            peek = pm_q[a];
        else if (s == SEL_CM && a < CM_DEPTH)
            peek = {16'h0000, cm_q[a]};
        else if (s == SEL_OM && a < OM_DEPTH)
            peek = {16'h0000, om_q[a[4:0]]};
    endfunction

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            p_q  <= 8'h00;
        end else begin
            s1_q <= {hard_jump_input, link.processor_reset_n,
                     link.converter_reset_n, link.frame_clock,
                     link.write_request_n, link.chip_select_n,
                     link.serial_in, link.serial_clock};
            s2_q <= s1_q;
            p_q  <= s2_q;
        end
    end

    assign sck      = s2_q[0];
    assign si       = s2_q[1];
    assign active   = !s2_q[2] && !s2_q[3];
    assign in_rst   = !s2_q[5] && !s2_q[6];
    assign sck_rise = s2_q[0] && !p_q[0];
    assign sck_fall = !s2_q[0] && p_q[0];
    assign si_rise  = s2_q[1] && !p_q[1];
    assign si_fall  = !s2_q[1] && p_q[1];
    assign wrq_fall = !s2_q[3] && p_q[3];
    assign lr       = s2_q[4] ^ ctrl_reg_q[CTRL_I2S_BIT];
    assign lr_p     = p_q[4] ^ ctrl_reg_q[CTRL_I2S_BIT];
    assign lr_rise  = lr && !lr_p;

    assign collect   = st_q inside {ST_CMD, ST_ADH, ST_ADL, ST_DATA};
    assign byte_done = active && collect && sck_rise && bit_q == 3'h7;
    assign rx_byte   = {sh_q, si};
    assign wdata     = {word_q, rx_byte};
    assign commit    = st_q == ST_DATA && byte_done &&
                       dcnt_q == last_idx(cmd_q);
    assign rw_hit    = exec_valid && rw_act_q && exec_kind == rw_kind_q &&
                       exec_addr == rw_addr_q;

    // byte assembly, MSB first
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !active) begin
            bit_q <= 3'h0;
            sh_q  <= 7'h00;
        end else if (collect && sck_rise) begin
            sh_q  <= {sh_q[5:0], si};
            bit_q <= bit_q + 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q       <= ST_CMD;
            cmd_q      <= 8'h00;
            addr_q     <= 9'h000;
            word_q     <= 24'h000000;
            dcnt_q     <= 2'h0;
            wait_q     <= 4'h0;
            ctrl_reg_q <= CTRL_RST;
            jump_code_q <= JUMP_RST;
            jpend_q    <= JUMP_RST;
            ready_q    <= 1'b1;
            bcnt_q     <= 5'h00;
            rw_act_q   <= 1'b0;
            rw_kind_q  <= 1'b0;
            rw_addr_q  <= 9'h000;
            rw_idx_q   <= 5'h00;
        end else begin
            if (rw_hit) begin
                rw_addr_q <= rw_addr_q + 9'h001;
                rw_idx_q  <= rw_idx_q + 5'h01;
                if (rw_idx_q + 5'h01 >= bcnt_q)
                    rw_act_q <= 1'b0;
            end
            if (wrq_fall && !(st_q inside {ST_BUSY, ST_JWAIT})) begin
                st_q <= ST_CMD;
            end else begin
                unique case (st_q)
                    ST_CMD: if (byte_done) begin
                        cmd_q  <= rx_byte;
                        dcnt_q <= 2'h0;
                        addr_q <= 9'h000;
                        if (rx_byte == CMD_PREP)
                            bcnt_q <= 5'h00;
                        if (!cmd_ok(rx_byte, in_rst))
                            st_q <= ST_HOLD;
                        else if (rx_byte == CMD_OM_RD)
                            st_q <= ST_ADL;
                        else if (rx_byte inside {CMD_OM_WR, CMD_CTRL,
                                                 CMD_JCON, CMD_PREP})
                            st_q <= ST_DATA;
                        else
                            st_q <= ST_ADH;
                    end
                    ST_ADH: if (byte_done) begin
                        addr_q[8] <= rx_byte[0];
                        st_q      <= ST_ADL;
                    end
                    ST_ADL: if (byte_done) begin
                        addr_q[7:0] <= cmd_q == CMD_OM_RD ? 8'h00 : rx_byte;
                        if (cmd_q inside {CMD_PM_RD, CMD_CM_RD, CMD_OM_RD}) begin
                            st_q <= ST_RARM;
                        end else if (cmd_q inside {CMD_CM_RW, CMD_OM_RW}) begin
                            rw_act_q  <= bcnt_q != 5'h00;
                            rw_kind_q <= cmd_q == CMD_OM_RW;
                            rw_addr_q <= {addr_q[8], rx_byte};
                            rw_idx_q  <= 5'h00;
                            ready_q   <= 1'b0;
                            st_q      <= ST_JWAIT;
                        end else begin
                            st_q <= ST_DATA;
                        end
                    end
                    ST_DATA: if (byte_done) begin
                        word_q <= wdata[23:0];
                        dcnt_q <= dcnt_q + 2'h1;
                        if (commit) begin
                            ready_q <= 1'b0;
                            if (cmd_q == CMD_JCON) begin
                                jpend_q <= rx_byte;
                                st_q    <= ST_JWAIT;
                            end else begin
                                wait_q <= WRITE_CYC;
                                st_q   <= ST_BUSY;
                            end
                            if (cmd_q == CMD_CTRL)
                                ctrl_reg_q <= wdata[15:0];
                            if (cmd_q inside {CMD_PM_WR, CMD_CM_WR, CMD_OM_WR})
                                addr_q <= addr_q + 9'h001;
                            if (cmd_q == CMD_PREP && bcnt_q < 5'h10)
                                bcnt_q <= bcnt_q + 5'h01;
                        end
                    end
                    ST_BUSY: begin
                        wait_q <= wait_q - 4'h1;
                        if (wait_q == 4'h1) begin
                            ready_q <= 1'b1;
                            dcnt_q  <= 2'h0;
                            st_q <= cmd_q == CMD_CTRL ? ST_HOLD : ST_DATA;
                        end
                    end
                    ST_JWAIT: if (lr_rise) begin
                        if (cmd_q == CMD_JCON)
                            jump_code_q <= jpend_q;
                        ready_q <= 1'b1;
                        st_q    <= ST_HOLD;
                    end
                    ST_RARM: if (si && !sck)
                        st_q <= cmd_q == CMD_PM_RD ? ST_RSHIFT : ST_RLOW;
                    ST_RLOW: if (si_fall)
                        st_q <= ST_RSHIFT;
                    ST_RSHIFT: if (si_rise) begin
                        addr_q <= addr_q + 9'h001;
                        st_q   <= ST_RARM;
                    end
                    ST_HOLD: ;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (commit) begin
            if (cmd_q == CMD_PM_WR && addr_q < PM_DEPTH)
                pm_q[addr_q] <= wdata;
            if (cmd_q == CMD_CM_WR && addr_q < CM_DEPTH)
                cm_q[addr_q] <= wdata[15:0];
            if (cmd_q == CMD_OM_WR && addr_q < OM_DEPTH)
                om_q[addr_q[4:0]] <= wdata[15:0];
            if (cmd_q == CMD_PREP && bcnt_q < 5'h10)
                buf_q[bcnt_q[3:0]] <= wdata[15:0];
        end
        if (rw_hit) begin
            if (rw_kind_q && exec_addr < OM_DEPTH)
                om_q[exec_addr[4:0]] <= buf_q[rw_idx_q[3:0]];
            else if (!rw_kind_q && exec_addr < CM_DEPTH)
                cm_q[exec_addr] <= buf_q[rw_idx_q[3:0]];
        end
    end

    // read shifter, left-justified, shifts on SCLK fall
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            rsh_q <= 32'h0000_0000;
        else if (st_q == ST_RARM && si && !sck) begin
            if (cmd_q == CMD_PM_RD)
                rsh_q <= peek(SEL_PM, addr_q);
            else if (cmd_q == CMD_CM_RD)
                rsh_q <= peek(SEL_CM, addr_q) << 16;
            else
                rsh_q <= peek(SEL_OM, addr_q) << 16;
        end else if (st_q == ST_RSHIFT && sck_fall)
            rsh_q <= {rsh_q[30:0], 1'b0};
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            jump_taken_q <= 1'b0;
            user_data_q  <= 32'h0000_0000;
            in_reset_q   <= 1'b0;
        end else begin
            jump_taken_q <= |(jump_condition_field &
                              {s2_q[7], jump_code_q});
            user_data_q  <= peek(user_sel, user_addr);
            in_reset_q   <= in_rst;
        end
    end

    assign link.serial_out = rsh_q[31];
    assign link.host_ready = ready_q;
endmodule
`default_nettype wire

/* verilog/hsl_host_end.sv */
`timescale 1ns/10ps
`default_nettype none
module hsl_host_end
    import hsl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    hsl_link_if.host         link,
    input  wire logic        op_valid,
    input  wire hsl_op_t     op_kind,
    input  wire logic [7:0]  op_byte,
    input  wire logic [5:0]  op_bits,
    input  wire logic        hold_reset,
    output logic             op_ready_q,
    output logic      [31:0] rd_data_q,
    output logic             rd_valid_q,
    output logic             cs_n_q,
    output logic             wrq_n_q,
    output logic             sclk_q,
    output logic             si_q,
    output logic             rst_n_q
);
    typedef enum logic [3:0] {
        H_IDLE, H_RDY, H_BIT, H_GUARD, H_WQHI,
        H_RSIL, H_RBIT, H_LRF, H_LRN
    } hsl_hst_t;

    hsl_hst_t    st_q;
    logic [2:0]  s1_q, s2_q;
    logic        lr_p_q, lr_fall, tick;
    logic [4:0]  hc_q;
    logic [7:0]  sh_q, gcnt_q;
    logic [5:0]  cnt_q;
    logic [31:0] rsh_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s1_q   <= 3'h0;
            s2_q   <= 3'h0;
            lr_p_q <= 1'b0;
        end else begin
            s1_q   <= {link.frame_clock, link.serial_out, link.host_ready};
            s2_q   <= s1_q;
            lr_p_q <= s2_q[2];
        end
    end
    assign lr_fall = lr_p_q && !s2_q[2];

    // serial clock half-period divider
    always_ff @(posedge sys_clk) begin
        if (sys_rst || hc_q == 5'h00)
            hc_q <= HALF_CYC - 5'h01;
        else
            hc_q <= hc_q - 5'h01;
    end
    assign tick = hc_q == 5'h00;

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            rst_n_q <= 1'b0;
        else
            rst_n_q <= !hold_reset;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q       <= H_IDLE;
            op_ready_q <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_data_q  <= 32'h0000_0000;
            cs_n_q     <= 1'b1;
            wrq_n_q    <= 1'b1;
            sclk_q     <= 1'b1;
            si_q       <= 1'b0;
            sh_q       <= 8'h00;
            cnt_q      <= 6'h00;
            gcnt_q     <= 8'h00;
            rsh_q      <= 32'h0000_0000;
        end else begin
            cs_n_q     <= 1'b0;
            rd_valid_q <= 1'b0;
            unique case (st_q)
                H_IDLE: begin
                    op_ready_q <= 1'b1;
                    if (op_valid && op_ready_q) begin
                        op_ready_q <= 1'b0;
                        sh_q   <= op_byte;
                        cnt_q  <= op_bits;
                        gcnt_q <= GUARD_CYC;
                        unique case (op_kind)
                            HOP_BYTE: st_q <= H_RDY;
                            HOP_READ: begin
                                sclk_q <= 1'b0;
                                si_q   <= 1'b1;
                                st_q   <= H_RSIL;
                            end
                            HOP_RESTART: begin
                                wrq_n_q <= 1'b1;
                                st_q    <= H_WQHI;
                            end
                            HOP_RELEASE: st_q <= H_LRF;
                        endcase
                    end
                end
                H_RDY: if (s2_q[0] && tick) begin
                    wrq_n_q <= 1'b0;
                    cnt_q   <= 6'h08;
                    st_q    <= H_BIT;
                end
                H_BIT: if (tick) begin
                    if (sclk_q) begin
                        sclk_q <= 1'b0;
                        si_q   <= sh_q[7];
                        sh_q   <= {sh_q[6:0], 1'b0};
                    end else begin
                        sclk_q <= 1'b1;
                        cnt_q  <= cnt_q - 6'h01;
                        if (cnt_q == 6'h01) begin
                            gcnt_q <= GUARD_CYC;
                            st_q   <= H_GUARD;
                        end
                    end
                end
                H_GUARD: begin
                    gcnt_q <= gcnt_q - 8'h01;
                    if (gcnt_q == 8'h00)
                        st_q <= H_IDLE;
                end
                H_WQHI: begin
                    gcnt_q <= gcnt_q - 8'h01;
                    if (gcnt_q == 8'h00) begin
                        wrq_n_q <= 1'b0;
                        gcnt_q  <= GUARD_CYC;
                        st_q    <= H_GUARD;
                    end
                end
                H_RSIL: begin
                    gcnt_q <= gcnt_q - 8'h01;
                    if (gcnt_q == 8'h00) begin
                        si_q <= 1'b0;
                        st_q <= H_RBIT;
                    end
                end
                H_RBIT: if (tick) begin
                    if (!sclk_q) begin
                        sclk_q <= 1'b1;
                    end else begin
                        rsh_q  <= {rsh_q[30:0], s2_q[1]};
                        sclk_q <= 1'b0;
                        cnt_q  <= cnt_q - 6'h01;
                        if (cnt_q <= 6'h01) begin
                            rd_data_q  <= {rsh_q[30:0], s2_q[1]};
                            rd_valid_q <= 1'b1;
                            sclk_q     <= 1'b1;
                            gcnt_q     <= GUARD_CYC;
                            st_q       <= H_GUARD;
                        end
                    end
                end
                H_LRF: if (lr_fall) begin
                    cnt_q <= FRAME_WAIT_SLAVE;
                    st_q  <= H_LRN;
                end
                H_LRN: if (lr_fall) begin
                    cnt_q <= cnt_q - 6'h01;
                    if (cnt_q == 6'h01) begin
                        wrq_n_q <= 1'b1;
                        gcnt_q  <= GUARD_CYC;
                        st_q    <= H_GUARD;
                    end
                end
            endcase
        end
    end

    assign link.chip_select_n     = cs_n_q;
    assign link.write_request_n   = wrq_n_q;
    assign link.serial_clock      = sclk_q;
    assign link.serial_in         = si_q;
    assign link.converter_reset_n = rst_n_q;
    assign link.processor_reset_n = rst_n_q;
endmodule
`default_nettype wire

/* tb/hsl_link_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module hsl_link_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic chip_select_n,
    input wire logic write_request_n,
    input wire logic serial_clock,
    input wire logic serial_out,
    input wire logic host_ready,
    input wire logic converter_reset_n,
    input wire logic processor_reset_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence low_hold;
        !host_ready [*3];
    endsequence
    sequence back_up;
        ##[1:1000] host_ready;
    endsequence
    pair_rst_a: assert property (converter_reset_n == processor_reset_n)
        else $error("reset pins differ");
    rel_ready_a: assert property ($fell(sys_rst) |-> host_ready)
        else $error("ready low after reset");
    ready_min_a: assert property ($fell(host_ready) |-> low_hold)
        else $error("ready pulse too short");
    ready_back_a: assert property ($fell(host_ready) |-> back_up)
        else $error("ready stuck low");
    fall_sel_a: assert property ($fell(host_ready) |-> !chip_select_n)
        else $error("ready fell while deselected");
    so_steady_a: assert property (serial_clock [*6] |-> $stable(serial_out))
        else $error("serial out moved with clock high");
    wrq_ready_a: assert property ($fell(write_request_n) |-> host_ready)
        else $error("request while busy");
    idle_sclk_a: assert property (write_request_n |-> serial_clock)
        else $error("serial clock low without request");
endmodule
`default_nettype wire

/* tb/dsp_host_serial_loader_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module dsp_host_serial_loader_tb;
    import hsl_pkg::*;
    logic        sys_clk    = 1'b0;
    logic        sys_rst    = 1'b1;
    logic        op_valid   = 1'b0;
    logic        hold_reset = 1'b1;
    hsl_op_t     op_kind    = HOP_BYTE;
    logic [7:0]  op_byte    = 8'h00;
    logic [5:0]  op_bits    = 6'h00;
    logic [1:0]  user_sel   = 2'h0;
    logic [8:0]  user_addr  = 9'h000;
    logic [7:0]  fcnt       = 8'h00;
    logic [8:0]  jcf        = 9'h000;
    logic        exec_valid = 1'b0;
    logic [8:0]  exec_addr  = 9'h000;
    logic        jump_taken_q;
    logic        op_ready_q;
    logic [31:0] rd_data_q;
    logic [31:0] user_data_q;
    logic [15:0] ctrl_reg_q;
    logic [7:0]  jump_code_q;
    int          err_total  = 0;
    int          check_count = 0;
    hsl_link_if lnk ();
    assign lnk.frame_clock = fcnt[7];
    initial forever #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) fcnt <= fcnt + 8'h01;
    hsl_host_end hsl_host_end_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .link(lnk), .op_valid(op_valid), .op_kind(op_kind),
        .op_byte(op_byte), .op_bits(op_bits), .hold_reset(hold_reset),
        .op_ready_q(op_ready_q), .rd_data_q(rd_data_q), .rd_valid_q(),
        .cs_n_q(), .wrq_n_q(), .sclk_q(), .si_q(), .rst_n_q());
    hsl_dev_end hsl_dev_end_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .link(lnk), .hard_jump_input(1'b0), .jump_condition_field(jcf),
        .exec_valid(exec_valid), .exec_kind(1'b0), .exec_addr(exec_addr),
        .user_sel(user_sel), .user_addr(user_addr),
        .user_data_q(user_data_q), .ctrl_reg_q(ctrl_reg_q),
        .jump_code_q(jump_code_q), .jump_taken_q(jump_taken_q), .in_reset_q(),
        .ready_q(), .rsh_q());
    hsl_link_chk hsl_link_chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .chip_select_n(lnk.chip_select_n),
        .write_request_n(lnk.write_request_n),
        .serial_clock(lnk.serial_clock), .serial_out(lnk.serial_out),
        .host_ready(lnk.host_ready),
        .converter_reset_n(lnk.converter_reset_n),
        .processor_reset_n(lnk.processor_reset_n));
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt();
        do @(negedge sys_clk); while (op_ready_q !== 1'b1);
    endtask
    task automatic op(input hsl_op_t k, input logic [7:0] b,
                      input logic [5:0] n);
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op_kind <= k;
        op_byte <= b;
        op_bits <= n;
        wt();
        @(posedge sys_clk);
        op_valid <= 1'b0;
    endtask
    task automatic by(input logic [63:0] d, input int n);
        for (int i = n - 1; i >= 0; i--)
            op(HOP_BYTE, d[i*8 +: 8], 6'h00);
        wt();
    endtask
    task automatic wr(input logic [63:0] d, input int n);
        op(HOP_RESTART, 8'h00, 6'h00);
        by(d, n);
    endtask
    task automatic pk(input logic [1:0] s, input logic [8:0] a,
                      input logic [31:0] e);
        @(posedge sys_clk);
        user_sel <= s;
        user_addr <= a;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("user_data", e, user_data_q);
    endtask
    task automatic rd(input logic [63:0] d, input int c,
                      input logic [5:0] n, input logic [31:0] e);
        wr(d, c);
        op(HOP_READ, 8'h00, n);
        wt();
        chk("read", e, rd_data_q & ((32'h1 << n) - 32'h1));
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wr(64'h06_1234, 3);
        chk("ctrl", 32'h1234, {16'h0, ctrl_reg_q});
        wr(64'hC0_01BE_11223344, 7);
        by(64'h55667788, 4);
        pk(SEL_PM, 9'h1BE, 32'h11223344);
        pk(SEL_PM, 9'h1BF, 32'h55667788);
        wr(64'hA0_0102_ABCD, 5);
        by(64'hBEEF, 2);
        pk(SEL_CM, 9'h103, 32'hBEEF);
        wr(64'h90_1357, 3);
        by(64'h2468, 2);
        pk(SEL_OM, 9'h001, 32'h2468);
        rd(64'hC3_01BE, 3, 6'd32, 32'h11223344);
        op(HOP_READ, 8'h00, 6'd32);
        wt();
        chk("read", 32'h55667788, rd_data_q);
        rd(64'hA1_0102, 3, 6'd16, 32'hABCD);
        rd(64'h91_00, 2, 6'd16, 32'h1357);
        wr(64'hC4_5A, 2);
        repeat (300) @(posedge sys_clk);
        chk("jump", 32'h5A, {24'h0, jump_code_q});
        jcf <= 9'h1A5;
        repeat (3) @(posedge sys_clk);
        chk("taken", 32'h0, {31'h0, jump_taken_q});
        jcf <= 9'h002;
        repeat (3) @(posedge sys_clk);
        chk("taken", 32'h1, {31'h0, jump_taken_q});
        hold_reset <= 1'b0;
        op(HOP_RELEASE, 8'h00, 6'h00);
        wt();
        chk("request", 32'h1, {31'h0, lnk.write_request_n});
        wr(64'h06_0FFF, 3);
        chk("ctrl", 32'h1234, {16'h0, ctrl_reg_q});
        wr(64'hC4_A5, 2);
        repeat (300) @(posedge sys_clk);
        chk("jump", 32'hA5, {24'h0, jump_code_q});
        wr(64'h88_1111_2222, 5);
        wr(64'hA4_0005, 3);
        @(posedge sys_clk);
        exec_valid <= 1'b1;
        exec_addr <= 9'h005;
        @(posedge sys_clk);
        exec_addr <= 9'h006;
        @(posedge sys_clk);
        exec_valid <= 1'b0;
        pk(SEL_CM, 9'h005, 32'h1111);
        pk(SEL_CM, 9'h006, 32'h2222);
        end_of_test();
    end
endmodule
`default_nettype wire
